/* File: rtl/mc_timer_pkg.sv */
// Constants shared by the machine-cycle timer/counter and its phase sequencer.
package mc_timer_pkg;
  // Register addresses on the special-function bus.
  localparam logic [7:0] CTRL01_ADDR = 8'h88;
  localparam logic [7:0] MODE_CFG_ADDR = 8'h89;
  localparam logic [7:0] CTRL2_ADDR = 8'hc8;
  localparam logic [7:0] PLL_ADDR = 8'hd7;
  localparam logic [7:0] TL_ADDR [3] = '{8'h8a, 8'h8b, 8'hcc};
  localparam logic [7:0] TH_ADDR [3] = '{8'h8c, 8'h8d, 8'hcd};
  // Reset values.
  localparam logic [7:0] MODE_CFG_RESET = 8'h00;
  localparam logic [7:0] CTRL01_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [2:0] PLL_RESET = 3'h3;
  // Field positions in the mode register, per timer nibble.
  localparam int MODE_LO = 0;
  localparam int MODE_HI = 1;
  localparam int CT_BIT = 2;
  localparam int GATE_BIT = 3;
  localparam int UNIT1_NIBBLE = 4;
  // Field positions in the control registers.
  localparam int OVF1_BIT = 7;
  localparam int RUN1_BIT = 6;
  localparam int OVF0_BIT = 5;
  localparam int RUN0_BIT = 4;
  localparam int OVF2_BIT = 7;
  localparam int RUN2_BIT = 2;
  localparam int CT2_BIT = 1;
  // Timer modes.
  localparam logic [1:0] MODE_13BIT = 2'b00;
  localparam logic [1:0] MODE_16BIT = 2'b01;
  localparam logic [1:0] MODE_RELOAD = 2'b10;
  localparam logic [1:0] MODE_SPLIT = 2'b11;
  // Machine cycle phases: S1P1 is phase 0, S6P2 is phase 11.
  localparam int PHASES_PER_CYCLE = 12;
  localparam logic [3:0] PHASE_UPDATE = 4'h4;
  localparam logic [3:0] PHASE_SAMPLE = 4'h9;
  localparam int DIV_CNT_W = 7;
endpackage : mc_timer_pkg

/* File: rtl/mc_phase_seq.sv */
// Core clock divider and machine-cycle phase sequencer.
`timescale 1ns/1ps
module mc_phase_seq
  import mc_timer_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_reset_n, // Asynchronous reset, active low.
  input wire logic [2:0] i_div_sel, // Core clock divider select.
  output logic o_core_en, // One-cycle core clock enable.
  output logic o_sample_stb, // Input sampling point strobe.
  output logic o_update_stb // Count update point strobe.
);
  logic [DIV_CNT_W-1:0] div_ff;
  logic [DIV_CNT_W-1:0] div_limit;
  logic [3:0] phase_ff;

  assign div_limit = DIV_CNT_W'((1 << i_div_sel) - 1);
  assign o_core_en = (div_ff >= div_limit);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_ff <= '0;
    end else if (o_core_en) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_ff <= '0;
    end else if (o_core_en) begin
      phase_ff <= (phase_ff == 4'(PHASES_PER_CYCLE - 1)) ? 4'h0 : phase_ff + 4'h1;
    end
  end

  assign o_sample_stb = o_core_en && (phase_ff == PHASE_SAMPLE);
  assign o_update_stb = o_core_en && (phase_ff == PHASE_UPDATE);
endmodule : mc_phase_seq

/* File: rtl/mc_timer.sv */
// Three 16-bit machine-cycle timer/counters with their special-function registers.
`timescale 1ns/1ps
module mc_timer
  import mc_timer_pkg::*;
(
  input wire logic i_clk, // System clock, 40 MHz.
  input wire logic i_reset_n, // Asynchronous reset, active low.
  input wire logic [7:0] i_sfr_addr, // Register address.
  input wire logic i_sfr_wr, // Register write strobe.
  input wire logic i_sfr_rd, // Register read strobe.
  input wire logic [7:0] i_sfr_wdata, // Register write data.
  output logic [7:0] o_sfr_rdata, // Registered read data.
  input wire logic [2:0] i_ext_count_input, // Count input pins, unit 0 to 2.
  input wire logic [1:0] i_ext_interrupt_pin, // Interrupt pins 0 and 1, gate inputs.
  input wire logic [2:0] i_vector_ack, // Pulse when the core vectors to a timer handler.
  output logic [2:0] o_overflow_flag // Overflow flags, unit 0 to 2.
);
  logic [7:0] timer01_mode_config_ff;
  logic [7:0] timer01_control_ff;
  logic [7:0] timer2_control_ff;
  logic [7:0] nxt_timer01_control;
  logic [7:0] nxt_timer2_control;
  logic [2:0] core_clock_divider_select_ff;
  logic [2:0][7:0] count_low_byte_ff;
  logic [2:0][7:0] count_high_byte_ff;
  logic [2:0][7:0] nxt_low;
  logic [2:0][7:0] nxt_high;
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic [1:0] int_meta_ff;
  logic [1:0] int_sync_ff;
  logic [2:0] sample_ff;
  logic [2:0] fall_pend_ff;
  logic [2:0] tick;
  logic [2:0] unit_ovf;
  logic [2:0] flag_set;
  logic [2:0] run;
  logic [2:0] ct;
  logic [2:0] gate_ok;
  logic [1:0] mode [3];
  logic split_mode;
  logic split_high_tick;
  logic split_high_ovf;
  logic core_en;
  logic sample_stb;
  logic update_stb;

  function automatic logic wr_hit(input logic [7:0] a);
    return i_sfr_wr && (i_sfr_addr == a);
  endfunction : wr_hit

  // Returns {overflow, high, low} after one count in the given mode.
  function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] hi, input logic [7:0] lo);
    logic [13:0] p13;
    logic [8:0] p8;
    logic [16:0] r;
    p13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    p8 = {1'b0, lo} + 9'h001;
    r = {1'b0, hi, lo};
    unique case (m)
      MODE_13BIT: r = {p13[13], p13[12:5], lo[7:5], p13[4:0]};
      MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
      MODE_RELOAD: r = {p8[8], hi, p8[8] ? hi : p8[7:0]};
      MODE_SPLIT: r = {p8[8], hi, p8[7:0]};
    endcase
    return r;
  endfunction : step

  mc_phase_seq u_seq (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_div_sel(core_clock_divider_select_ff),
    .o_core_en(core_en),
    .o_sample_stb(sample_stb),
    .o_update_stb(update_stb)
  );

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      int_meta_ff <= '0;
      int_sync_ff <= '0;
    end else begin
      pin_meta_ff <= i_ext_count_input;
      pin_sync_ff <= pin_meta_ff;
      int_meta_ff <= i_ext_interrupt_pin;
      int_sync_ff <= int_meta_ff;
    end
  end

  // Sample at S5P2, detect high then low.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sample_ff <= '0;
      fall_pend_ff <= '0;
    end else if (sample_stb) begin
      sample_ff <= pin_sync_ff;
      fall_pend_ff <= sample_ff & ~pin_sync_ff;
    end
  end

  // Unit controls from shared and own registers.
  assign run[0] = timer01_control_ff[RUN0_BIT];
  assign run[1] = timer01_control_ff[RUN1_BIT];
  assign run[2] = timer2_control_ff[RUN2_BIT];
  assign ct[0] = timer01_mode_config_ff[CT_BIT];
  assign ct[1] = timer01_mode_config_ff[UNIT1_NIBBLE + CT_BIT];
  assign ct[2] = timer2_control_ff[CT2_BIT];
  assign gate_ok[0] = !timer01_mode_config_ff[GATE_BIT] || int_sync_ff[0];
  assign gate_ok[1] = !timer01_mode_config_ff[UNIT1_NIBBLE + GATE_BIT] || int_sync_ff[1];
  assign gate_ok[2] = 1'b1;
  assign mode[0] = {timer01_mode_config_ff[MODE_HI], timer01_mode_config_ff[MODE_LO]};
  assign mode[1] = {timer01_mode_config_ff[UNIT1_NIBBLE + MODE_HI], timer01_mode_config_ff[UNIT1_NIBBLE + MODE_LO]};
  assign mode[2] = MODE_16BIT;
  assign split_mode = (mode[0] == MODE_SPLIT);
  // Split high byte counts machine cycles under timer 1 run.
  assign split_high_tick = split_mode && update_stb && run[1];

  always_comb begin
    logic [16:0] r;
    logic [8:0] h;
    r = '0;
    h = '0;
    split_high_ovf = 1'b0;
    for (int i = 0; i < 3; i++) begin
      // Count at S3P1, timer or edge.
      tick[i] = update_stb && run[i] && gate_ok[i] && (!ct[i] || fall_pend_ff[i]);
      if (i == 1 && mode[1] == MODE_SPLIT) begin
        tick[i] = 1'b0;
      end
      r = step(mode[i], count_high_byte_ff[i], count_low_byte_ff[i]);
      unit_ovf[i] = tick[i] && r[16];
      nxt_low[i] = tick[i] ? r[7:0] : count_low_byte_ff[i];
      nxt_high[i] = tick[i] ? r[15:8] : count_high_byte_ff[i];
      if (i == 0 && split_high_tick) begin
        h = {1'b0, count_high_byte_ff[0]} + 9'h001;
        nxt_high[0] = h[7:0];
        split_high_ovf = h[8];
      end
      if (wr_hit(TL_ADDR[i])) begin
        nxt_low[i] = i_sfr_wdata;
      end
      if (wr_hit(TH_ADDR[i])) begin
        nxt_high[i] = i_sfr_wdata;
      end
    end
  end

  // Timer 1 flag taken by the split high byte.
  assign flag_set[0] = unit_ovf[0];
  assign flag_set[1] = split_mode ? split_high_ovf : unit_ovf[1];
  assign flag_set[2] = unit_ovf[2];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_low_byte_ff <= '0;
      count_high_byte_ff <= '0;
    end else begin
      count_low_byte_ff <= nxt_low;
      count_high_byte_ff <= nxt_high;
    end
  end

  // Byte-wide mode register, cleared at reset.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer01_mode_config_ff <= MODE_CFG_RESET;
    end else if (wr_hit(MODE_CFG_ADDR)) begin
      timer01_mode_config_ff <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_clock_divider_select_ff <= PLL_RESET;
    end else if (wr_hit(PLL_ADDR)) begin
      core_clock_divider_select_ff <= i_sfr_wdata[2:0];
    end
  end

  // Flags: vector clears, overflow set wins.
  always_comb begin
    nxt_timer01_control = wr_hit(CTRL01_ADDR) ? i_sfr_wdata : timer01_control_ff;
    nxt_timer2_control = wr_hit(CTRL2_ADDR) ? i_sfr_wdata : timer2_control_ff;
    nxt_timer01_control[OVF0_BIT] = flag_set[0] || (nxt_timer01_control[OVF0_BIT] && !i_vector_ack[0]);
    nxt_timer01_control[OVF1_BIT] = flag_set[1] || (nxt_timer01_control[OVF1_BIT] && !i_vector_ack[1]);
    nxt_timer2_control[OVF2_BIT] = flag_set[2] || (nxt_timer2_control[OVF2_BIT] && !i_vector_ack[2]);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer01_control_ff <= CTRL01_RESET;
      timer2_control_ff <= CTRL2_RESET;
    end else begin
      timer01_control_ff <= nxt_timer01_control;
      timer2_control_ff <= nxt_timer2_control;
    end
  end

  assign o_overflow_flag = {timer2_control_ff[OVF2_BIT], timer01_control_ff[OVF1_BIT], timer01_control_ff[OVF0_BIT]};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sfr_rdata <= '0;
    end else if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        MODE_CFG_ADDR: o_sfr_rdata <= timer01_mode_config_ff;
        CTRL01_ADDR: o_sfr_rdata <= timer01_control_ff;
        CTRL2_ADDR: o_sfr_rdata <= timer2_control_ff;
        PLL_ADDR: o_sfr_rdata <= {5'h00, core_clock_divider_select_ff};
        TL_ADDR[0]: o_sfr_rdata <= count_low_byte_ff[0];
        TL_ADDR[1]: o_sfr_rdata <= count_low_byte_ff[1];
        TL_ADDR[2]: o_sfr_rdata <= count_low_byte_ff[2];
        TH_ADDR[0]: o_sfr_rdata <= count_high_byte_ff[0];
        TH_ADDR[1]: o_sfr_rdata <= count_high_byte_ff[1];
        TH_ADDR[2]: o_sfr_rdata <= count_high_byte_ff[2];
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Checks. A small counter measures core enables between sampling points.
  logic [3:0] gap_ff;
  logic seen_ff;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_ff <= '0;
      seen_ff <= 1'b0;
    end else if (sample_stb) begin
      gap_ff <= '0;
      seen_ff <= 1'b1;
    end else if (core_en) begin
      gap_ff <= gap_ff + 4'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sample_spacing_a: assert property (sample_stb && seen_ff |-> gap_ff == 4'(PHASES_PER_CYCLE - 1))
    else $error("sampling points not twelve core clocks apart");
  mode_write_a: assert property (wr_hit(MODE_CFG_ADDR) |=> timer01_mode_config_ff == $past(i_sfr_wdata))
    else $error("mode register write lost");
  timer_step_a: assert property (update_stb && mode[0] == MODE_16BIT && run[0] && gate_ok[0] && !ct[0]
    && !wr_hit(TL_ADDR[0]) |=> count_low_byte_ff[0] == $past(count_low_byte_ff[0]) + 8'h01)
    else $error("timer did not count a machine cycle");
  no_edge_hold_a: assert property (ct[1] && mode[1] == MODE_16BIT && !fall_pend_ff[1] && !wr_hit(TL_ADDR[1])
    |=> $stable(count_low_byte_ff[1]))
    else $error("counter advanced without an edge");
  edge_detect_a: assert property (sample_stb && sample_ff[2] && !pin_sync_ff[2] |=> fall_pend_ff[2])
    else $error("falling edge not detected");
  edge_count_a: assert property (update_stb && fall_pend_ff[2] && run[2] && ct[2] && !wr_hit(TL_ADDR[2])
    |=> count_low_byte_ff[2] == $past(count_low_byte_ff[2]) + 8'h01)
    else $error("counted edge not visible at update point");
  gate_block_a: assert property (timer01_mode_config_ff[GATE_BIT] && !int_sync_ff[0] && !wr_hit(TL_ADDR[0])
    |=> $stable(count_low_byte_ff[0]))
    else $error("gated timer counted with pin low");
  reload_a: assert property (unit_ovf[0] && mode[0] == MODE_RELOAD && !wr_hit(TL_ADDR[0]) && !wr_hit(TH_ADDR[0])
    |=> count_low_byte_ff[0] == count_high_byte_ff[0])
    else $error("auto-reload did not load high byte");
  flag_set_a: assert property (flag_set[0] |=> o_overflow_flag[0])
    else $error("overflow did not set flag");
  flag_clear_a: assert property (i_vector_ack[1] && !flag_set[1] && !wr_hit(CTRL01_ADDR) |=> !o_overflow_flag[1])
    else $error("vectoring did not clear flag");
  split_high_a: assert property (split_high_tick && !wr_hit(TH_ADDR[0])
    |=> count_high_byte_ff[0] == $past(count_high_byte_ff[0]) + 8'h01)
    else $error("split high byte did not count");

  cover_edge_c: cover property (fall_pend_ff[0] && tick[0] && ct[0]);
  cover_reload_c: cover property (unit_ovf[1] && mode[1] == MODE_RELOAD);
  cover_split_c: cover property (split_high_ovf);
  cover_t2_ovf_c: cover property (unit_ovf[2]);
endmodule : mc_timer

/* File: test/count_source.sv */
// Event source that drives the three count input pins.
`timescale 1ns/1ps
module count_source (
  input wire logic i_clk, // System clock.
  output logic [2:0] o_pin // Count input pins, pulled high when idle.
);
  initial o_pin = 3'h7;

  task automatic falls(input int unit, input int n, input int hold);
    repeat (n) begin
      @(posedge i_clk);
      o_pin[unit] <= 1'b0;
      repeat (hold) @(posedge i_clk);
      o_pin[unit] <= 1'b1;
      repeat (hold) @(posedge i_clk);
    end
  endtask : falls
endmodule : count_source

/* File: test/testbench.sv */
// Self-checking testbench for the machine-cycle timer/counter.
`timescale 1ns/1ps
module testbench;
  import mc_timer_pkg::*;
  logic i_clk;
  logic i_reset_n;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [2:0] pins;
  logic [1:0] int_pins;
  logic [2:0] vector_ack;
  logic [2:0] flags;
  logic [7:0] a;
  logic [7:0] b;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  mc_timer i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
    .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_ext_count_input(pins),
    .i_ext_interrupt_pin(int_pins), .i_vector_ack(vector_ack), .o_overflow_flag(flags));
  count_source i_src (.i_clk(i_clk), .o_pin(pins));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    sfr_addr <= addr;
    sfr_wdata <= data;
    sfr_wr <= 1'b1;
    @(posedge i_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clk);
    sfr_addr <= addr;
    sfr_rd <= 1'b1;
    @(posedge i_clk);
    sfr_rd <= 1'b0;
    #1 data = sfr_rdata;
  endtask : rd

  // Two reads exactly 120 clocks apart, ten machine cycles at divider select 0.
  task automatic rate(input logic [7:0] addr, input logic [7:0] exp_diff);
    rd(addr, a);
    repeat (118) @(posedge i_clk);
    rd(addr, b);
    check(b - a, exp_diff);
  endtask : rate

  // Waits up to 40 clocks for one overflow flag to rise.
  task automatic wait_flag(input int unit);
    for (int i = 0; i < 40 && flags[unit] !== 1'b1; i++) @(posedge i_clk);
  endtask : wait_flag

  // Gives one vector acknowledge pulse and returns once the flag has settled.
  task automatic ack(input int unit);
    @(posedge i_clk);
    vector_ack[unit] <= 1'b1;
    @(posedge i_clk);
    vector_ack[unit] <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask : ack

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  initial begin
    i_reset_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    int_pins = 2'h3;
    vector_ack = 3'h0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(MODE_CFG_ADDR, a);
    check(a, 8'h00);
    rd(CTRL01_ADDR, a);
    check(a, 8'h00);
    rd(CTRL2_ADDR, a);
    check(a, 8'h00);
    rd(PLL_ADDR, a);
    check(a & 8'h07, 8'h03);
    rd(8'h80, a);
    check(a, 8'h00);
    wr(MODE_CFG_ADDR, 8'h5a);
    rd(MODE_CFG_ADDR, a);
    check(a, 8'h5a);
    wr(PLL_ADDR, 8'h00);
    $display("Test registers done");
    wr(MODE_CFG_ADDR, 8'h01);
    wr(TL_ADDR[0], 8'h00);
    wr(CTRL01_ADDR, 8'h10);
    rate(TL_ADDR[0], 8'h0a);
    wr(CTRL01_ADDR, 8'h00);
    wr(TL_ADDR[0], 8'hff);
    wr(TH_ADDR[0], 8'hff);
    wr(CTRL01_ADDR, 8'h10);
    wait_flag(0);
    check({7'h0, flags[0]}, 8'h01);
    rd(TH_ADDR[0], a);
    check(a, 8'h00);
    ack(0);
    check({7'h0, flags[0]}, 8'h00);
    $display("Test timer rate and overflow done");
    wr(CTRL01_ADDR, 8'h00);
    wr(MODE_CFG_ADDR, 8'h02);
    wr(TH_ADDR[0], 8'hf0);
    wr(TL_ADDR[0], 8'hfe);
    wr(CTRL01_ADDR, 8'h10);
    wait_flag(0);
    rd(TL_ADDR[0], a);
    check(a, 8'hf0);
    wr(CTRL01_ADDR, 8'h00);
    $display("Test auto-reload done");
    wr(MODE_CFG_ADDR, 8'h09);
    int_pins <= 2'h2;
    wr(CTRL01_ADDR, 8'h10);
    rate(TL_ADDR[0], 8'h00);
    int_pins <= 2'h3;
    repeat (24) @(posedge i_clk);
    rate(TL_ADDR[0], 8'h0a);
    wr(CTRL01_ADDR, 8'h00);
    // Timer 1 gated by its own pin, then counting in the prescaled mode.
    wr(MODE_CFG_ADDR, 8'h80);
    int_pins <= 2'h1;
    wr(TL_ADDR[1], 8'hfe);
    wr(TH_ADDR[1], 8'h00);
    wr(CTRL01_ADDR, 8'h40);
    rate(TL_ADDR[1], 8'h00);
    int_pins <= 2'h3;
    repeat (60) @(posedge i_clk);
    rd(TH_ADDR[1], a);
    check(a, 8'h01);
    rd(TL_ADDR[1], a);
    check(a & 8'he0, 8'he0);
    wr(CTRL01_ADDR, 8'h00);
    $display("Test gating done");
    wr(MODE_CFG_ADDR, 8'h50);
    wr(TL_ADDR[1], 8'h00);
    wr(CTRL01_ADDR, 8'h40);
    i_src.falls(1, 5, 12);
    repeat (48) @(posedge i_clk);
    rd(TL_ADDR[1], a);
    check(a, 8'h05);
    wr(MODE_CFG_ADDR, 8'h30);
    rate(TL_ADDR[1], 8'h00);
    wr(CTRL01_ADDR, 8'h00);
    // Split timer 0: the high byte runs on timer 1's run bit and flag.
    wr(MODE_CFG_ADDR, 8'h33);
    wr(TH_ADDR[0], 8'hfe);
    wr(TL_ADDR[0], 8'h00);
    wr(CTRL01_ADDR, 8'h40);
    wait_flag(1);
    check({6'h0, flags[1:0]}, 8'h02);
    rd(TH_ADDR[0], a);
    check(a, 8'h00);
    rd(TL_ADDR[0], a);
    check(a, 8'h00);
    ack(1);
    check({7'h0, flags[1]}, 8'h00);
    wr(CTRL01_ADDR, 8'h00);
    $display("Test split mode done");
    wr(TL_ADDR[2], 8'h00);
    wr(CTRL2_ADDR, 8'h06);
    i_src.falls(2, 3, 24);
    repeat (48) @(posedge i_clk);
    rd(TL_ADDR[2], a);
    check(a, 8'h03);
    wr(CTRL2_ADDR, 8'h00);
    wr(TL_ADDR[2], 8'hff);
    wr(TH_ADDR[2], 8'hff);
    wr(CTRL2_ADDR, 8'h04);
    wait_flag(2);
    check({5'h0, flags}, 8'h04);
    ack(2);
    check({5'h0, flags}, 8'h00);
    $display("Test counters done");
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(MODE_CFG_ADDR, a);
    check(a, 8'h00);
    rd(PLL_ADDR, a);
    check(a, 8'h03);
    $display("Test reset done");
    end_sim();
  end
endmodule : testbench
